// ### rtl/rcdpc_check.sv
// Contract
// - capture command, address, parity and chip selects on every rising clock edge.
// - parity check enable bit lives in a control word, changed by control writes.
// - checking on: forward a sampled command only when its parity was good.
// - checking off: forward every selected command that is not a control write, regardless of parity.
// - control word writes get the same parity check unless checking is off.
// - host supplies parity bit per command; device compares it with received lines.
// - open-drain alert pulled low when a parity error is found.
// - good parity means even ones; checked only when some chip select is low.
// - parity covers activate, three command lines, bank group, bank and address 16..0.
`timescale 1ns/1ps
module rcdpc_check
  import rcdpc_pkg::*;
#(
  parameter int NCS = CS_W
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              act_n_in,
  input  wire logic [CMD_W-1:0]  cmd_in,
  input  wire logic [BG_W-1:0]   bg_in,
  input  wire logic [BA_W-1:0]   ba_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              cmd_parity_in,
  input  wire logic [NCS-1:0]    chip_select_in,
  input  wire logic              ctl_write_in,
  input  wire logic              ctl_par_en_in,
  output logic                   fwd_valid_out,
  output logic                   fwd_act_n_out,
  output logic [CMD_W-1:0]       fwd_cmd_out,
  output logic [BG_W-1:0]        fwd_bg_out,
  output logic [BA_W-1:0]        fwd_ba_out,
  output logic [ADDR_W-1:0]      fwd_addr_out,
  output logic [NCS-1:0]         fwd_cs_out,
  output logic                   alert_n_o_out,
  output logic                   alert_n_oe_out,
  output logic                   parity_control_word_out
);
  initial begin
    if (NCS < 1) $error("rcdpc_check: NCS must be at least one");
  end

  function automatic logic odd_ones(input logic [PAR_W-1:0] v);
    odd_ones = ^v;
  endfunction

  // input register stage, every rising edge
  logic              act_n_r;
  logic [CMD_W-1:0]  cmd_r;
  logic [BG_W-1:0]   bg_r;
  logic [BA_W-1:0]   ba_r;
  logic [ADDR_W-1:0] addr_r;
  logic              par_r;
  logic [NCS-1:0]    cs_r;
  logic              wr_r;
  logic              wr_data_r;
  logic              par_en_r;
  logic              par_en_nxt;
  logic              fwd_r;
  logic              fwd_nxt;
  logic              err_r;
  logic              err_nxt;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      act_n_r   <= 1'b1;
      cmd_r     <= '0;
      bg_r      <= '0;
      ba_r      <= '0;
      addr_r    <= '0;
      par_r     <= 1'b0;
      cs_r      <= '1;
      wr_r      <= 1'b0;
      wr_data_r <= 1'b0;
    end else begin
      act_n_r   <= act_n_in;
      cmd_r     <= cmd_in;
      bg_r      <= bg_in;
      ba_r      <= ba_in;
      addr_r    <= addr_in;
      par_r     <= cmd_parity_in;
      cs_r      <= chip_select_in;
      wr_r      <= ctl_write_in;
      wr_data_r <= ctl_par_en_in;
    end
  end

  wire logic [PAR_W-1:0] par_vec = {act_n_r, cmd_r, bg_r, ba_r, addr_r};
  wire logic             sel     = ~&cs_r;
  wire logic             bad     = odd_ones(par_vec) ^ par_r;
  wire logic             chk_err = sel & par_en_r & bad;

  // control word write only lands when parity passes or checking is off
  assign par_en_nxt = (sel & wr_r & ~chk_err) ? wr_data_r : par_en_r;
  assign fwd_nxt    = sel & ~wr_r & ~chk_err;
  assign err_nxt    = chk_err;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      par_en_r <= PAR_EN_RST;
      fwd_r    <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      par_en_r <= par_en_nxt;
      fwd_r    <= fwd_nxt;
      err_r    <= err_nxt;
    end
  end

  // forwarded command bus
  logic [PAR_W+NCS-1:0] hold_q;
  rcdpc_hold #(
    .W(PAR_W + NCS)
  ) u_hold (
    .clk_in  (clk_in),
    .rst_n_in(rst_n_in),
    .load_in (fwd_nxt),
    .d_in    ({par_vec, cs_r}),
    .q_out   (hold_q)
  );

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fwd_valid_out           <= 1'b0;
      alert_n_o_out           <= 1'b0;
      alert_n_oe_out          <= 1'b0;
      parity_control_word_out <= PAR_EN_RST;
    end else begin
      fwd_valid_out           <= fwd_r;
      alert_n_o_out           <= 1'b0;
      alert_n_oe_out          <= err_r;
      parity_control_word_out <= par_en_r;
    end
  end

  assign {fwd_act_n_out, fwd_cmd_out, fwd_bg_out, fwd_ba_out, fwd_addr_out, fwd_cs_out} = hold_q;

  property p_cap;
    @(posedge clk_in) disable iff (!rst_n_in)
      1'b1 |=> (addr_r == $past(addr_in)) && (par_r == $past(cmd_parity_in));
  endproperty
  a_cap: assert property (p_cap) else $error("inputs not captured");

  property p_nofwd_err;
    @(posedge clk_in) disable iff (!rst_n_in)
      chk_err |-> ##2 !fwd_valid_out;
  endproperty
  a_nofwd_err: assert property (p_nofwd_err) else $error("errored command forwarded");

  property p_fwd_off;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!par_en_r && sel && !wr_r) |-> ##2 fwd_valid_out;
  endproperty
  a_fwd_off: assert property (p_fwd_off) else $error("command dropped with checking off");

  property p_cw_blocked;
    @(posedge clk_in) disable iff (!rst_n_in)
      (wr_r && chk_err) |=> $stable(par_en_r);
  endproperty
  a_cw_blocked: assert property (p_cw_blocked) else $error("bad control write took effect");

  property p_cw_taken;
    @(posedge clk_in) disable iff (!rst_n_in)
      (wr_r && sel && !chk_err) |-> ##2 (parity_control_word_out == $past(wr_data_r, 2));
  endproperty
  a_cw_taken: assert property (p_cw_taken) else $error("control write lost");

  property p_alert;
    @(posedge clk_in) disable iff (!rst_n_in)
      chk_err |-> ##2 (alert_n_oe_out && !alert_n_o_out);
  endproperty
  a_alert: assert property (p_alert) else $error("alert not driven low");

  property p_idle;
    @(posedge clk_in) disable iff (!rst_n_in)
      (&cs_r) |-> ##2 (!fwd_valid_out && !alert_n_oe_out);
  endproperty
  a_idle: assert property (p_idle) else $error("activity while deselected");

  property p_even;
    @(posedge clk_in) disable iff (!rst_n_in)
      (sel && par_en_r && (^{par_vec, par_r} == 1'b0)) |-> ##2 !alert_n_oe_out;
  endproperty
  a_even: assert property (p_even) else $error("alert on even parity");

  property p_cmp;
    @(posedge clk_in) disable iff (!rst_n_in)
      (sel && par_en_r && (^{act_n_r, cmd_r, bg_r, ba_r, addr_r, par_r})) |-> ##2 alert_n_oe_out;
  endproperty
  a_cmp: assert property (p_cmp) else $error("odd parity missed");

  property p_fwd_bus;
    @(posedge clk_in) disable iff (!rst_n_in)
      fwd_nxt |=> ({fwd_act_n_out, fwd_cmd_out, fwd_bg_out, fwd_ba_out, fwd_addr_out} == $past(par_vec))
                  && (fwd_cs_out == $past(cs_r));
  endproperty
  a_fwd_bus: assert property (p_fwd_bus) else $error("forwarded bus differs from capture");

  // dropped commands must not disturb what the drams last saw
  property p_bus_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      !fwd_nxt |=> $stable({fwd_act_n_out, fwd_cmd_out, fwd_bg_out, fwd_ba_out, fwd_addr_out, fwd_cs_out});
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("forwarded bus changed without forward");

  property p_off_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
      !par_en_r |-> ##2 !alert_n_oe_out;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("alert while checking off");

  property p_cw_not_fwd;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_r |-> ##2 !fwd_valid_out;
  endproperty
  a_cw_not_fwd: assert property (p_cw_not_fwd) else $error("control write forwarded");

  property p_cw_only;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!wr_r || !sel) |=> $stable(par_en_r);
  endproperty
  a_cw_only: assert property (p_cw_only) else $error("enable changed without control write");

  property p_alert_cause;
    @(posedge clk_in) disable iff (!rst_n_in)
      alert_n_oe_out |-> $past(sel && par_en_r && bad, 2);
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without odd parity");
endmodule

// ### rtl/rcdpc_hold.sv
`timescale 1ns/1ps
module rcdpc_hold
  import rcdpc_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  initial begin
    if (W < 1) $error("rcdpc_hold: W must be positive");
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q_out <= '0;
    end else if (load_in) begin
      q_out <= d_in;
    end
  end
endmodule

// ### rtl/rcdpc_pkg.sv
package rcdpc_pkg;
  localparam int ADDR_W       = 17;
  localparam int BG_W         = 2;
  localparam int BA_W         = 2;
  localparam int CS_W         = 2;
  localparam int CMD_W        = 3;
  // parity vector: act, cmd[2:0], bg, ba, addr
  localparam int PAR_W        = 1 + CMD_W + BG_W + BA_W + ADDR_W;
  localparam logic PAR_EN_RST = 1'b1;
  localparam int CMD_DATA_W   = PAR_W + CS_W;
endpackage

// ### sim/rcd_command_parity_check_tb_top.sv
`timescale 1ns/1ps
module rcd_command_parity_check_tb_top
  import rcdpc_pkg::*;
;
  logic              clk_in = 0, rst_n_in = 0, bad = 0, cw = 0, en = 1;
  logic [PAR_W-1:0]  vec = '0;
  logic [CS_W-1:0]   cs = '1;
  logic              act_n, par, v, a_o, a_oe, pcw;
  logic [CMD_W-1:0]  cmd;
  logic [BG_W-1:0]   bg;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr, f_addr;
  logic [CS_W-1:0]   f_cs;
  logic              f_act_n;
  logic [CMD_W-1:0]  f_cmd;
  logic [BG_W-1:0]   f_bg;
  logic [BA_W-1:0]   f_ba;
  int                n_mismatch = 0, total_checks = 0;
  always #2 clk_in = ~clk_in;
  rcdpc_host_model host (.vec_in(vec), .bad_in(bad), .act_n_out(act_n), .cmd_out(cmd), .bg_out(bg),
    .ba_out(ba), .addr_out(addr), .par_out(par));
  rcdpc_check dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .act_n_in(act_n), .cmd_in(cmd), .bg_in(bg),
    .ba_in(ba), .addr_in(addr), .cmd_parity_in(par), .chip_select_in(cs), .ctl_write_in(cw),
    .ctl_par_en_in(en), .fwd_valid_out(v), .fwd_act_n_out(f_act_n), .fwd_cmd_out(f_cmd), .fwd_bg_out(f_bg),
    .fwd_ba_out(f_ba), .fwd_addr_out(f_addr), .fwd_cs_out(f_cs), .alert_n_o_out(a_o),
    .alert_n_oe_out(a_oe), .parity_control_word_out(pcw));
  task fail(input string m);
    n_mismatch++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  // outputs judged three edges after the command was presented
  task send(input logic w, e, b, input logic [CS_W-1:0] c, input logic [PAR_W-1:0] d,
            input logic ev, ea, ep);
    vec = d;
    bad = b;
    cw = w;
    en = e;
    cs = c;
    @(posedge clk_in) #1;
    cs = '1;
    cw = 0;
    repeat (2) @(posedge clk_in);
    #1;
    total_checks += 4;
    if (v !== ev) fail("forward pulse");
    if (a_oe !== ea || a_o !== 1'b0) fail("alert");
    if (ev && ({f_act_n, f_cmd, f_bg, f_ba, f_addr} !== d || f_cs !== c)) fail("forwarded bus");
    if (pcw !== ep) fail("enable word");
  endtask
  task t_check_on;
    send(0, 1, 0, 2'h2, 25'h0a5_a5a5, 1, 0, 1);
    send(0, 1, 1, 2'h1, 25'h1ff_0001, 0, 1, 1);
    send(0, 1, 1, 2'h3, 25'h0a5_a5a5, 0, 0, 1);
  endtask
  task t_ctl_write;
    send(1, 0, 1, 2'h2, 25'h012_3456, 0, 1, 1);
    send(1, 0, 0, 2'h2, 25'h012_3456, 0, 0, 0);
  endtask
  task t_check_off;
    send(0, 1, 1, 2'h0, 25'h1ff_0001, 1, 0, 0);
    send(1, 1, 1, 2'h1, 25'h000_0007, 0, 0, 1);
  endtask
  task report_and_stop;
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge clk_in);
    #1 rst_n_in = 1;
    @(posedge clk_in) #1;
    t_check_on;
    t_ctl_write;
    t_check_off;
    report_and_stop;
  end
endmodule

// ### sim/rcdpc_host_model.sv
`timescale 1ns/1ps
module rcdpc_host_model
  import rcdpc_pkg::*;
(
  input  wire logic [PAR_W-1:0]  vec_in,
  input  wire logic              bad_in,
  output logic                   act_n_out,
  output logic [CMD_W-1:0]       cmd_out,
  output logic [BG_W-1:0]        bg_out,
  output logic [BA_W-1:0]        ba_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   par_out
);
  // field order follows the parity vector
  assign {act_n_out, cmd_out, bg_out, ba_out, addr_out} = vec_in;
  // even ones overall; bad_in breaks it on purpose
  assign par_out = (^vec_in) ^ bad_in;
endmodule
